// ===== cce_condition_code_evaluator.sv
// Top: condition code evaluator with combinational and registered result
// ==========================================
// How it works
// - Four-bit subcode, sixteen codes; each odd code inverts the even one below.
// - 0000 true on overflow set, 0001 clear; 0010 carry set, 0011 clear.
// - 0100 zero set, 0101 clear; 0110 carry or zero, 0111 neither.
// - 1000 sign set, 1001 clear; 1010 parity set, 1011 clear.
// - 1100 sign differs from overflow; 1101 sign equals overflow.
// - 1110 (sign xor overflow) or zero; 1111 that term is zero.
// - Above/below use carry (and zero); greater/less use sign, overflow (and zero).
// - Synonymous condition names share one subcode and one identical flag test.
// - One table serves jumps, moves, floating-point moves and set-on-condition.
`timescale 1ns/10ps
`default_nettype none
module cce_condition_code_evaluator #(
   parameter int SUBCODE_W = cce_pkg::SUBCODE_W
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [SUBCODE_W-1:0] condSubcode,
   input wire logic [cce_pkg::FLAGS_W-1:0] flagsWord,
   input wire logic [1:0] opGroup,
   input wire logic evalValid,
   output logic condTrue,
   output logic condTrueReg,
   output logic condValidReg
);
   // ==========================================
   // Elaboration checks
   // The table below is built for sixteen entries, so no other width can be served
   localparam int BASE_COUNT = cce_pkg::TABLE_SIZE / 2;

   if (SUBCODE_W != cce_pkg::SUBCODE_W) begin : gBadWidth
      $error("condition subcode must be four bits wide");
   end

   if (cce_pkg::TABLE_SIZE != (1 << cce_pkg::SUBCODE_W)) begin : gBadTable
      $error("condition table must hold one entry per subcode");
   end

   if (BASE_COUNT != (1 << $bits(cce_pkg::cce_base_t))) begin : gBadBase
      $error("base test count must match the base test encoding");
   end

   // The lowest subcode bit is the inversion, the rest select a base test
   if (SUBCODE_W - 1 != $bits(cce_pkg::cce_base_t)) begin : gBadSelect
      $error("base test select must be one bit narrower than the subcode");
   end

   if ($bits(opGroup) != $bits(cce_pkg::cce_group_t)) begin : gBadGroup
      $error("group selector width must match the group encoding");
   end

   // A misplaced flag would silently test the wrong condition
   if (cce_pkg::FLAG_CARRY >= cce_pkg::FLAGS_W) begin : gCarryHigh
      $error("carry flag position lies above the flags word");
   end

   if (cce_pkg::FLAG_PARITY >= cce_pkg::FLAGS_W) begin : gParityHigh
      $error("parity flag position lies above the flags word");
   end

   if (cce_pkg::FLAG_ZERO >= cce_pkg::FLAGS_W) begin : gZeroHigh
      $error("zero flag position lies above the flags word");
   end

   if (cce_pkg::FLAG_SIGN >= cce_pkg::FLAGS_W) begin : gSignHigh
      $error("sign flag position lies above the flags word");
   end

   if (cce_pkg::FLAG_OVERFLOW >= cce_pkg::FLAGS_W) begin : gOverflowHigh
      $error("overflow flag position lies above the flags word");
   end

   if (cce_pkg::FLAG_CARRY < 0) begin : gCarryLow
      $error("carry flag position is negative");
   end

   if (cce_pkg::FLAG_PARITY < 0) begin : gParityLow
      $error("parity flag position is negative");
   end

   if (cce_pkg::FLAG_ZERO < 0) begin : gZeroLow
      $error("zero flag position is negative");
   end

   if (cce_pkg::FLAG_SIGN < 0) begin : gSignLow
      $error("sign flag position is negative");
   end

   if (cce_pkg::FLAG_OVERFLOW < 0) begin : gOverflowLow
      $error("overflow flag position is negative");
   end

   // Two flags sharing one bit would make their tests indistinguishable
   if (cce_pkg::FLAG_CARRY == cce_pkg::FLAG_PARITY) begin : gCarryParity
      $error("carry and parity flags share a bit");
   end

   if (cce_pkg::FLAG_CARRY == cce_pkg::FLAG_ZERO) begin : gCarryZero
      $error("carry and zero flags share a bit");
   end

   if (cce_pkg::FLAG_CARRY == cce_pkg::FLAG_SIGN) begin : gCarrySign
      $error("carry and sign flags share a bit");
   end

   if (cce_pkg::FLAG_CARRY == cce_pkg::FLAG_OVERFLOW) begin : gCarryOverflow
      $error("carry and overflow flags share a bit");
   end

   if (cce_pkg::FLAG_PARITY == cce_pkg::FLAG_ZERO) begin : gParityZero
      $error("parity and zero flags share a bit");
   end

   if (cce_pkg::FLAG_PARITY == cce_pkg::FLAG_SIGN) begin : gParitySign
      $error("parity and sign flags share a bit");
   end

   if (cce_pkg::FLAG_PARITY == cce_pkg::FLAG_OVERFLOW) begin : gParityOverflow
      $error("parity and overflow flags share a bit");
   end

   if (cce_pkg::FLAG_ZERO == cce_pkg::FLAG_SIGN) begin : gZeroSign
      $error("zero and sign flags share a bit");
   end

   if (cce_pkg::FLAG_ZERO == cce_pkg::FLAG_OVERFLOW) begin : gZeroOverflow
      $error("zero and overflow flags share a bit");
   end

   if (cce_pkg::FLAG_SIGN == cce_pkg::FLAG_OVERFLOW) begin : gSignOverflow
      $error("sign and overflow flags share a bit");
   end

   // ==========================================
   // Flag extraction
   // Named copies keep the base tests independent of where each flag sits in the word
   logic carryFlag;
   logic parityFlag;
   logic zeroFlag;
   logic signFlag;
   logic overflowFlag;

   always_comb begin
      carryFlag = flagsWord[cce_pkg::FLAG_CARRY];
      parityFlag = flagsWord[cce_pkg::FLAG_PARITY];
      zeroFlag = flagsWord[cce_pkg::FLAG_ZERO];
      signFlag = flagsWord[cce_pkg::FLAG_SIGN];
      overflowFlag = flagsWord[cce_pkg::FLAG_OVERFLOW];
   end

   // ==========================================
   // Condition table
   logic [BASE_COUNT-1:0] baseTrue;
   logic [cce_pkg::TABLE_SIZE-1:0] condTable;

   // All base tests run side by side and the subcode only picks an entry:
   // eight small evaluators are traded for a short select path
   for (genvar k = 0; k < BASE_COUNT; k++) begin : gBase
      cce_base_test uBase (
         .baseSel(3'(k)),
         .carryFlag(carryFlag),
         .overflowFlag(overflowFlag),
         .signFlag(signFlag),
         .zeroFlag(zeroFlag),
         .parityFlag(parityFlag),
         .baseTrue(baseTrue[k])
      );

      // Even entry is the test itself, the odd entry just above it its complement
      assign condTable[2*k] = baseTrue[k];
      assign condTable[2*k+1] = ~baseTrue[k];
   end

   // ==========================================
   // Selection
   // Synonymous condition names reach one subcode and so one entry; they cannot diverge
   logic evalTrue;

   always_comb begin
      evalTrue = condTable[condSubcode];
   end

   // Same-cycle answer for the execute stage; the only output not taken from a flip-flop
   assign condTrue = evalTrue;

   // ==========================================
   // Instruction group
   // Accepted but never alters the decode: every group reads the same table
   logic [1:0] groupUnused;

   assign groupUnused = opGroup;

   // ==========================================
   // Optional registered copy for a later pipeline stage
   logic condTrue_reg;
   logic condTrue_next;
   logic condValid_reg;
   logic condValid_next;

   // The result holds while no evaluation is requested; valid is a one-cycle echo of the request
   always_comb begin
      condValid_next = evalValid;
      condTrue_next = evalValid ? evalTrue : condTrue_reg;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         condTrue_reg <= cce_pkg::RESULT_RESET;
         condValid_reg <= cce_pkg::VALID_RESET;
      end else begin
         condTrue_reg <= condTrue_next;
         condValid_reg <= condValid_next;
      end
   end

   assign condTrueReg = condTrue_reg;
   assign condValidReg = condValid_reg;
endmodule
`default_nettype wire

// ===== cce_pkg.sv
// Package: constants for the condition code evaluator
package cce_pkg;
   // Condition subcode width and table size
   localparam int SUBCODE_W = 4;
   localparam int TABLE_SIZE = 16;
   // Flag positions in the packed flags word handed to the evaluator
   localparam int FLAG_CARRY = 0;
   localparam int FLAG_PARITY = 1;
   localparam int FLAG_ZERO = 2;
   localparam int FLAG_SIGN = 3;
   localparam int FLAG_OVERFLOW = 4;
   localparam int FLAGS_W = 5;
   // Value of the registered result after reset
   localparam logic RESULT_RESET = 1'h0;
   // Value of the registered valid flag after reset
   localparam logic VALID_RESET = 1'h0;
   // Base tests, selected by subcode bits 3..1; bit 0 inverts
   typedef enum logic [2:0] {
      CCE_OVERFLOW,
      CCE_BELOW,
      CCE_EQUAL,
      CCE_BELOW_EQUAL,
      CCE_SIGN,
      CCE_PARITY,
      CCE_LESS,
      CCE_LESS_EQUAL
   } cce_base_t;
   // Instruction groups that share the table
   typedef enum logic [1:0] {
      CCE_GRP_JUMP,
      CCE_GRP_MOVE,
      CCE_GRP_FP_MOVE,
      CCE_GRP_SET
   } cce_group_t;
endpackage

// ===== cce_base_test.sv
// Evaluator of the eight base flag tests, purely combinational
`timescale 1ns/10ps
`default_nettype none
module cce_base_test (
   input wire logic [2:0] baseSel,
   input wire logic carryFlag,
   input wire logic overflowFlag,
   input wire logic signFlag,
   input wire logic zeroFlag,
   input wire logic parityFlag,
   output logic baseTrue
);
   logic signNeOverflow;
   always_comb begin
      signNeOverflow = signFlag ^ overflowFlag;
      unique case (cce_pkg::cce_base_t'(baseSel))
         cce_pkg::CCE_OVERFLOW: baseTrue = overflowFlag;
         cce_pkg::CCE_BELOW: baseTrue = carryFlag;
         cce_pkg::CCE_EQUAL: baseTrue = zeroFlag;
         cce_pkg::CCE_BELOW_EQUAL: baseTrue = carryFlag | zeroFlag;
         cce_pkg::CCE_SIGN: baseTrue = signFlag;
         cce_pkg::CCE_PARITY: baseTrue = parityFlag;
         cce_pkg::CCE_LESS: baseTrue = signNeOverflow;
         cce_pkg::CCE_LESS_EQUAL: baseTrue = signNeOverflow | zeroFlag;
      endcase
   end
endmodule
`default_nettype wire

// ===== cce_condition_code_evaluator_properties.sv
// Concurrent properties of the condition code evaluator
`timescale 1ns/10ps
`default_nettype none
module cce_condition_code_evaluator_properties #(parameter int SUBCODE_W = 4) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [SUBCODE_W-1:0] condSubcode,
   input wire logic [4:0] flagsWord,
   input wire logic [1:0] opGroup,
   input wire logic evalValid,
   input wire logic condTrue,
   input wire logic condTrueReg,
   input wire logic condValidReg
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   wire logic [4:0] f = flagsWord;
   wire logic [2:0] b = condSubcode[3:1];
   // Base test with the odd-code inversion undone
   wire logic v = condTrue ^ condSubcode[0];
   a_ovf_test: assert property (b == 3'h0 |-> v == f[4]) else $error("overflow test wrong");
   a_carry_test: assert property (b == 3'h1 |-> v == f[0]) else $error("carry test wrong");
   a_zero_test: assert property (b[2:1] == 2'h1 |-> v == (f[2] | (b[0] & f[0]))) else $error("zero test wrong");
   a_sign_par: assert property (b[2:1] == 2'h2 |-> v == (b[0] ? f[1] : f[3])) else $error("sign test wrong");
   a_less_test: assert property (b == 3'h6 |-> v == (f[3] ^ f[4])) else $error("less test wrong");
   a_less_equal: assert property (b == 3'h7 |-> v == ((f[3] ^ f[4]) | f[2])) else $error("le test wrong");
   a_group_ignored: assert property ($stable(condSubcode) && $stable(f) |-> $stable(condTrue)) else $error("group leak");
   a_reg_copy: assert property (evalValid |=> condTrueReg == $past(condTrue) && condValidReg) else $error("bad copy");
   a_hold_value: assert property (!evalValid |=> $stable(condTrueReg) && !condValidReg) else $error("no hold");
endmodule
bind cce_condition_code_evaluator cce_condition_code_evaluator_properties #(.SUBCODE_W(SUBCODE_W)) i_props (.clk_sys,
   .rstn, .condSubcode, .flagsWord, .opGroup, .evalValid, .condTrue, .condTrueReg, .condValidReg);
`default_nettype wire

// ===== cce_exec_model.sv
// Execute-stage model that consumes the registered condition results
`timescale 1ns/10ps
`default_nettype none
module cce_exec_model (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic condValidReg,
   input wire logic condTrueReg,
   output logic [9:0] takenCnt
);
   // Counts taken conditions, as a branch unit would redirect
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) takenCnt <= 10'h000;
      else if (condValidReg && condTrueReg) takenCnt <= takenCnt + 10'h001;
   end
endmodule
`default_nettype wire

// ===== cce_condition_code_evaluator_tb.sv
// Testbench for the condition code evaluator
`timescale 1ns/10ps
`default_nettype none
module cce_condition_code_evaluator_tb;
   logic clk_sys = 0, rstn = 0, evalValid = 0, condTrue, condTrueReg, condValidReg, prev = 0;
   logic [3:0] sc = 4'h0;
   logic [4:0] fw = 5'h00;
   logic [1:0] grp = 2'h0;
   logic [9:0] takenCnt, nTrue = 10'h000;
   int err_total = 0, checked = 0;
   always #5 clk_sys = ~clk_sys;
   cce_condition_code_evaluator i_cce_condition_code_evaluator (.clk_sys, .rstn, .condSubcode(sc), .flagsWord(fw),
      .opGroup(grp), .evalValid, .condTrue, .condTrueReg, .condValidReg);
   cce_exec_model i_cce_exec_model (.clk_sys, .rstn, .condValidReg, .condTrueReg, .takenCnt);
   // ==========
   // Checks
   function automatic logic exp_f(logic [3:0] s, logic [4:0] f);
      logic [7:0] t;
      t = {(f[3] ^ f[4]) | f[2], f[3] ^ f[4], f[1], f[3], f[0] | f[2], f[2], f[0], f[4]};
      return t[s[3:1]] ^ s[0];
   endfunction
   task check(input logic [9:0] seen, input logic [9:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // Every code against every flag value, back to back, group varied
   task sweep_all;
      for (int i = 0; i < 512; i++) begin
         @(posedge clk_sys);
         sc <= i[3:0];
         fw <= i[8:4];
         grp <= i[1:0] ^ i[5:4];
         evalValid <= 1'b1;
         #1 check(condTrue, exp_f(i[3:0], i[8:4]));
         if (i > 0) check(condTrueReg, prev);
         if (i > 0) check(condValidReg, 1'b1);
         prev = exp_f(i[3:0], i[8:4]);
         nTrue += prev;
      end
   endtask
   // Result stands while no evaluation is requested
   task hold_check;
      @(posedge clk_sys);
      evalValid <= 1'b0;
      fw <= ~fw;
      repeat (3) @(posedge clk_sys);
      #1 check(condTrueReg, prev);
      check(condValidReg, 1'b0);
      check(takenCnt, nTrue);
   endtask
   task print_verdict;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      sweep_all();
      hold_check();
      print_verdict();
   end
endmodule
`default_nettype wire
